//--- core/ppc_pkg.sv
package ppc_pkg;
    localparam int unsigned CLK_HZ           = 200000000;
    localparam int unsigned CNT_W            = 16;
    localparam int unsigned NUM_CNT          = 4;
    localparam int unsigned TIMED_W          = 16;
    localparam logic [15:0] TIMED_CYC_RST    = 16'h0064;
    localparam logic [15:0] PRESET_RST       = 16'h000A;

    // Register offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_PRE_A  = 4'h1;
    localparam logic [3:0] REG_PRE_B  = 4'h2;
    localparam logic [3:0] REG_TIMED  = 4'h3;
    localparam logic [3:0] REG_STAT   = 4'h4;
    localparam logic [3:0] REG_COUNT  = 4'h5;
    localparam logic [3:0] REG_MPRE0  = 4'h8;

    // Control fields
    localparam int unsigned CTRL_OMODE = 0;
    localparam int unsigned CTRL_VAR0  = 1;
    localparam int unsigned CTRL_VAR1  = 2;
    localparam int unsigned CTRL_RINV  = 3;

    typedef enum logic [1:0] {
        VAR_SINGLE = 2'b00,
        VAR_DUAL   = 2'b01,
        VAR_MULTI  = 2'b10,
        VAR_TOTAL  = 2'b11
    } ppc_var_t;

    typedef enum logic {
        OM_TIMED   = 1'b0,
        OM_LATCHED = 1'b1
    } ppc_omode_t;
endpackage

//--- core/ppc_mem.sv
module ppc_mem
    import ppc_pkg::*;
#(
    parameter int unsigned DEPTH = NUM_CNT,
    parameter int unsigned W     = CNT_W
) (
    // Clock
    input  wire logic                     clk_i,
    // Write port
    input  wire logic                     we_i,
    input  wire logic [$clog2(DEPTH)-1:0] wa_i,
    input  wire logic [W-1:0]             wd_i,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] ra_i,
    output logic      [W-1:0]             rd_o,
    // Flat view
    output logic      [DEPTH*W-1:0]       all_o
);
    logic [W-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[wa_i] <= wd_i;
        end
        rd_o <= mem_q[ra_i];
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_flat
        assign all_o[g*W +: W] = mem_q[g];
    end
endmodule // ppc_mem

//--- core/ppc_top.sv
// Function
// - Count pulses, assert output when count reaches or passes configured preset.
// - Dual variant holds two presets and drives two separate outputs.
// - Totalizing mode only shows the count, never drives outputs.
// - Multi variant runs several counters; any reaching preset fires output.
// - Timed mode pulses output for fixed time, then releases itself.
// - Timed mode clears count on count-up and keeps counting during output.
// - External reset or power loss clears the count mid-way.
// - Latched mode holds the output indefinitely after count-up.
// - In latched mode, reset clears both count and held output.
// - Auto clear takes one cycle; no pulse missed, resumes from zero.
// - External reset is a level; holds counter clear; polarity selectable.
module ppc_top
    import ppc_pkg::*;
(
    // Clock and reset
    input  wire logic               CLK_SYS_I,
    input  wire logic               RST_N_I,
    // Pins
    input  wire logic               PULSE_I,
    input  wire logic [NUM_CNT-1:0] MPULSE_I,
    input  wire logic               EXT_RST_I,
    // Register port
    input  wire logic [3:0]         ADDR_I,
    input  wire logic [31:0]        WDATA_I,
    input  wire logic               WR_I,
    input  wire logic               RD_I,
    output logic      [31:0]        RDATA_O,
    // Outputs
    output logic                    OUT_A_O,
    output logic                    OUT_B_O
);
    localparam int unsigned IW = $clog2(NUM_CNT);

    typedef struct packed {
        logic [1:0]               ps_a;
        logic [1:0]               ps_b;
        logic                     pd;
        logic [NUM_CNT-1:0]       mp1;
        logic [NUM_CNT-1:0]       mp2;
        logic [NUM_CNT-1:0]       mpd;
        logic [1:0]               rs;
        logic [3:0]               ctrl;
        logic [CNT_W-1:0]         pre_a;
        logic [CNT_W-1:0]         pre_b;
        logic [TIMED_W-1:0]       tcyc;
        logic [CNT_W-1:0]         cnt;
        logic [NUM_CNT*CNT_W-1:0] mcnt;
        logic [TIMED_W-1:0]       tmr_a;
        logic [TIMED_W-1:0]       tmr_b;
        logic                     out_a;
        logic                     out_b;
        logic                     rd_mem;
        logic [31:0]              rdata;
    } ppc_state_t;

    ppc_state_t s_q, s_d;
    logic [CNT_W-1:0]         mem_rd;
    logic [NUM_CNT*CNT_W-1:0] mpre;
    logic                     mem_we;

    assign mem_we = WR_I && (ADDR_I >= REG_MPRE0);

    ppc_mem #(.DEPTH(NUM_CNT), .W(CNT_W)) u_mem (
        .clk_i (CLK_SYS_I),
        .we_i  (mem_we),
        .wa_i  (ADDR_I[IW-1:0]),
        .wd_i  (WDATA_I[CNT_W-1:0]),
        .ra_i  (ADDR_I[IW-1:0]),
        .rd_o  (mem_rd),
        .all_o (mpre)
    );

    function automatic logic hit(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] p);
        return (c + CNT_W'(1)) >= p;
    endfunction

    logic       ext_clr, pe, fire_a, fire_b, mfire, timed, tot;
    ppc_var_t   var_m;
    logic [NUM_CNT-1:0] medge;

    always_comb begin
        s_d = s_q;
        var_m = ppc_var_t'({s_q.ctrl[CTRL_VAR1], s_q.ctrl[CTRL_VAR0]});
        timed = (s_q.ctrl[CTRL_OMODE] == OM_TIMED);
        tot   = (var_m == VAR_TOTAL);
        // Synchronisers
        s_d.ps_a = {s_q.ps_a[0], PULSE_I};
        s_d.pd   = s_q.ps_a[1];
        s_d.mp1  = MPULSE_I;
        s_d.mp2  = s_q.mp1;
        s_d.mpd  = s_q.mp2;
        s_d.rs   = {s_q.rs[0], EXT_RST_I};
        ext_clr  = s_q.rs[1] ^ s_q.ctrl[CTRL_RINV];
        pe       = s_q.ps_a[1] && !s_q.pd;
        medge    = s_q.mp2 & ~s_q.mpd;
        fire_a   = 1'b0;
        fire_b   = 1'b0;
        mfire    = 1'b0;
        // Register writes
        if (WR_I) begin
            case (ADDR_I)
                REG_CTRL:  s_d.ctrl  = WDATA_I[3:0];
                REG_PRE_A: s_d.pre_a = WDATA_I[CNT_W-1:0];
                REG_PRE_B: s_d.pre_b = WDATA_I[CNT_W-1:0];
                REG_TIMED: s_d.tcyc  = WDATA_I[TIMED_W-1:0];
                default:   ;
            endcase
        end
        // Main counter
        if (pe) begin
            if (!tot && (var_m != VAR_MULTI) && hit(s_q.cnt, s_q.pre_a)
                && (var_m == VAR_SINGLE || s_q.pre_a >= s_q.pre_b)) begin
                fire_a = 1'b1;
            end
            if (!tot && var_m == VAR_DUAL && hit(s_q.cnt, s_q.pre_b)) begin
                fire_b = 1'b1;
            end
            if (timed && (fire_a || (fire_b && s_q.pre_b >= s_q.pre_a))) begin
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + CNT_W'(1);
            end
        end
        if (var_m == VAR_DUAL && pe && !tot && hit(s_q.cnt, s_q.pre_a)) begin
            fire_a = 1'b1;
        end
        // Multi counters
        for (int i = 0; i < NUM_CNT; i++) begin
            if (medge[i] && var_m == VAR_MULTI) begin
                if (hit(s_q.mcnt[i*CNT_W +: CNT_W], mpre[i*CNT_W +: CNT_W])) begin
                    mfire = 1'b1;
                    if (timed) begin
                        s_d.mcnt[i*CNT_W +: CNT_W] = '0;
                    end else begin
                        s_d.mcnt[i*CNT_W +: CNT_W] = s_q.mcnt[i*CNT_W +: CNT_W] + CNT_W'(1);
                    end
                end else begin
                    s_d.mcnt[i*CNT_W +: CNT_W] = s_q.mcnt[i*CNT_W +: CNT_W] + CNT_W'(1);
                end
            end
        end
        fire_a = fire_a || mfire;
        // Outputs
        if (timed) begin
            if (fire_a) begin
                s_d.out_a = 1'b1;
                s_d.tmr_a = s_q.tcyc;
            end else if (s_q.tmr_a > TIMED_W'(1)) begin
                s_d.tmr_a = s_q.tmr_a - TIMED_W'(1);
            end else begin
                s_d.tmr_a = '0;
                s_d.out_a = 1'b0;
            end
            if (fire_b) begin
                s_d.out_b = 1'b1;
                s_d.tmr_b = s_q.tcyc;
            end else if (s_q.tmr_b > TIMED_W'(1)) begin
                s_d.tmr_b = s_q.tmr_b - TIMED_W'(1);
            end else begin
                s_d.tmr_b = '0;
                s_d.out_b = 1'b0;
            end
        end else begin
            s_d.out_a = s_q.out_a || fire_a;
            s_d.out_b = s_q.out_b || fire_b;
        end
        if (tot) begin
            s_d.out_a = 1'b0;
            s_d.out_b = 1'b0;
        end
        // External reset, level held
        if (ext_clr) begin
            s_d.cnt   = '0;
            s_d.mcnt  = '0;
            s_d.out_a = 1'b0;
            s_d.out_b = 1'b0;
            s_d.tmr_a = '0;
            s_d.tmr_b = '0;
        end
        // Register reads
        s_d.rd_mem = RD_I && (ADDR_I >= REG_MPRE0);
        s_d.rdata  = '0;
        if (RD_I) begin
            case (ADDR_I)
                REG_CTRL:  s_d.rdata = {28'h0000000, s_q.ctrl};
                REG_PRE_A: s_d.rdata = {16'h0000, s_q.pre_a};
                REG_PRE_B: s_d.rdata = {16'h0000, s_q.pre_b};
                REG_TIMED: s_d.rdata = {16'h0000, s_q.tcyc};
                REG_STAT:  s_d.rdata = {29'h0000000, ext_clr, s_q.out_b, s_q.out_a};
                REG_COUNT: s_d.rdata = {16'h0000, s_q.cnt};
                default:   s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            s_q       <= '0;
            s_q.pre_a <= PRESET_RST;
            s_q.pre_b <= PRESET_RST;
            s_q.tcyc  <= TIMED_CYC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA_O = s_q.rd_mem ? {16'h0000, mem_rd} : s_q.rdata;
    assign OUT_A_O = s_q.out_a;
    assign OUT_B_O = s_q.out_b;

    a_total_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (s_q.ctrl[CTRL_VAR1:CTRL_VAR0] == VAR_TOTAL) |=> !OUT_A_O && !OUT_B_O)
        else $error("output driven in totalizing mode");
    a_latch_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !timed && !tot && OUT_A_O && !ext_clr && $stable(s_q.ctrl) |=> OUT_A_O)
        else $error("latched output dropped");
    a_ext_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        ext_clr |=> (s_q.cnt == '0) && !OUT_A_O && !OUT_B_O)
        else $error("external reset did not clear");
    a_auto_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        timed && fire_a && (var_m == VAR_SINGLE) && !ext_clr |=> s_q.cnt == '0 && OUT_A_O)
        else $error("timed count-up did not restart");
    a_one_step: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !pe && !ext_clr |=> $stable(s_q.cnt))
        else $error("count moved without an edge");
    a_timed_end: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        timed && OUT_A_O && (s_q.tmr_a == '0) && !fire_a |=> !OUT_A_O)
        else $error("timed output did not end");
    a_fire_set: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        fire_a && !ext_clr && !tot |=> OUT_A_O)
        else $error("count-up did not assert output");
    a_timed_len: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        timed && fire_a && !ext_clr |=> s_q.tmr_a == $past(s_q.tcyc))
        else $error("timed length not loaded");
endmodule // ppc_top

//--- verif/ppc_pulse_src.sv
module ppc_pulse_src
    import ppc_pkg::*;
(
    // Clock
    input  wire logic             clk_i,
    // Request
    input  wire logic [NUM_CNT:0] fire_i,
    output logic                  busy_o,
    // Pins
    output logic                  pulse_o,
    output logic [NUM_CNT-1:0]    mpulse_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]       ph_q = 3'h0;
    logic [NUM_CNT:0] sel_q = '0;
    // Three cycles high, four low per pulse
    always_ff @(posedge clk_i) begin
        if (ph_q == 3'h0 && fire_i != '0) begin
            sel_q <= fire_i;
            ph_q  <= 3'h6;
        end else if (ph_q != 3'h0) begin
            ph_q <= ph_q - 3'h1;
        end
    end
    // Idle sensor lines sit low
    assign {mpulse_o, pulse_o} = (ph_q > 3'h3) ? sel_q : '0;
    assign busy_o = (ph_q != 3'h0);
endmodule // ppc_pulse_src

//--- verif/test_ppc_top.sv
module test_ppc_top
    import ppc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               ext_rst = 1'b0;
    logic [3:0]         addr = 4'h0;
    logic [31:0]        wdata = 32'h0;
    logic               wr = 1'b0;
    logic               rd = 1'b0;
    logic [NUM_CNT:0]   fire = '0;
    logic [31:0]        rdata;
    logic               out_a, out_b, busy, pulse;
    logic [NUM_CNT-1:0] mpulse;
    logic               rd_pend = 1'b0;
    logic [31:0]        exp_q[$];
    logic [7:0]         run = 8'h0;
    logic [7:0]         last_run = 8'h0;
    int                 mismatches = 0;
    int                 n_compared = 0;
    int                 seed = 76208;
    int                 p, k;

    initial forever #2.5 clk = ~clk;

    ppc_top u_dut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .PULSE_I(pulse), .MPULSE_I(mpulse),
        .EXT_RST_I(ext_rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .OUT_A_O(out_a), .OUT_B_O(out_b)
    );
    ppc_pulse_src u_src (
        .clk_i(clk), .fire_i(fire), .busy_o(busy), .pulse_o(pulse), .mpulse_o(mpulse)
    );

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        exp_q.push_back(exp);
        @(posedge clk);
    endtask

    task automatic pulses(input logic [NUM_CNT:0] m, input int n);
        repeat (n) begin
            fire <= m;
            @(posedge clk);
            fire <= '0;
            @(posedge clk);
            while (busy) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    task automatic do_rst;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    // Read data checker and output run length
    always @(posedge clk) begin
        if (rd_pend) chk("rdata", rdata, exp_q.pop_front());
        rd_pend <= rd;
        if (out_a) begin
            run <= run + 8'h1;
        end else if (run != 8'h0) begin
            last_run <= run;
            run      <= 8'h0;
        end
    end

    initial begin
        do_rst();
        rd_reg(REG_CTRL, 32'h0);
        rd_reg(REG_PRE_A, {16'h0, PRESET_RST});
        rd_reg(REG_TIMED, {16'h0, TIMED_CYC_RST});
        rd_reg(REG_COUNT, 32'h0);
        rd_reg(4'h7, 32'h0);
        $display("reset test done");
        p = 2 + ($random(seed) & 3);
        wr_reg(REG_PRE_A, 32'(p));
        wr_reg(REG_TIMED, 32'h14);
        pulses(5'h01, p - 1);
        rd_reg(REG_COUNT, 32'(p - 1));
        chk("out_a", {31'h0, out_a}, 32'h0);
        pulses(5'h01, 1);
        chk("out_a", {31'h0, out_a}, 32'h1);
        rd_reg(REG_COUNT, 32'h0);
        pulses(5'h01, 1);
        rd_reg(REG_COUNT, 32'h1);
        repeat (30) @(posedge clk);
        chk("out_width", {24'h0, last_run}, 32'h14);
        chk("out_a", {31'h0, out_a}, 32'h0);
        $display("timed test done");
        do_rst();
        wr_reg(REG_CTRL, 32'h1);
        pulses(5'h01, int'(PRESET_RST));
        repeat (50) @(posedge clk);
        chk("out_a", {31'h0, out_a}, 32'h1);
        ext_rst <= 1'b1;
        pulses(5'h01, 2);
        rd_reg(REG_STAT, 32'h4);
        rd_reg(REG_COUNT, 32'h0);
        ext_rst <= 1'b0;
        pulses(5'h01, 1);
        rd_reg(REG_COUNT, 32'h1);
        $display("latched test done");
        do_rst();
        wr_reg(REG_CTRL, 32'h3);
        wr_reg(REG_PRE_A, 32'h2);
        wr_reg(REG_PRE_B, 32'h4);
        pulses(5'h01, 2);
        rd_reg(REG_STAT, 32'h1);
        pulses(5'h01, 2);
        rd_reg(REG_STAT, 32'h3);
        chk("out_b", {31'h0, out_b}, 32'h1);
        do_rst();
        rd_reg(REG_STAT, 32'h0);
        $display("dual test done");
        wr_reg(REG_CTRL, 32'h6);
        wr_reg(REG_PRE_A, 32'h1);
        pulses(5'h01, 3);
        rd_reg(REG_COUNT, 32'h3);
        rd_reg(REG_STAT, 32'h0);
        $display("total test done");
        wr_reg(REG_CTRL, 32'h9);
        pulses(5'h01, 1);
        rd_reg(REG_STAT, 32'h4);
        rd_reg(REG_COUNT, 32'h0);
        ext_rst <= 1'b1;
        pulses(5'h01, 1);
        rd_reg(REG_COUNT, 32'h1);
        rd_reg(REG_STAT, 32'h1);
        ext_rst <= 1'b0;
        $display("inverted reset test done");
        do_rst();
        wr_reg(REG_CTRL, 32'h5);
        k = $random(seed) & 3;
        for (int i = 0; i < NUM_CNT; i++) wr_reg(REG_MPRE0 + 4'(i), 32'h3);
        rd_reg(REG_MPRE0 + 4'(k), 32'h3);
        pulses(5'(2 << k), 2);
        chk("out_a", {31'h0, out_a}, 32'h0);
        pulses(5'(2 << k), 1);
        chk("out_a", {31'h0, out_a}, 32'h1);
        $display("multi test done");
        summarize();
    end

    initial begin
        #50000;
        mismatches++;
        summarize();
    end
endmodule // test_ppc_top
